// File: verilog/crf_top.v
// command frame parser and answer builder for a wireless card reader link
// assumes a byte stream in, a byte stream out with ready, and AXI4-Lite software
`timescale 1ns/10ps
`default_nettype none
`include "crf_regs.vh"

module crf_top (
  input  wire        SYS_CLK_IN,
  input  wire        RESETN_IN,
  input  wire [7:0]  RX_DATA_IN,
  input  wire        RX_VALID_IN,
  output reg  [7:0]  TX_DATA_OUT,
  output reg         TX_VALID_OUT,
  output reg         TX_LAST_OUT,
  input  wire        TX_READY_IN,
  output reg         CARD_OFF_OUT,
  input  wire [7:0]  S_AXI_AWADDR_IN,
  input  wire        S_AXI_AWVALID_IN,
  output reg         S_AXI_AWREADY_OUT,
  input  wire [31:0] S_AXI_WDATA_IN,
  input  wire [3:0]  S_AXI_WSTRB_IN,
  input  wire        S_AXI_WVALID_IN,
  output reg         S_AXI_WREADY_OUT,
  output reg  [1:0]  S_AXI_BRESP_OUT,
  output reg         S_AXI_BVALID_OUT,
  input  wire        S_AXI_BREADY_IN,
  input  wire [7:0]  S_AXI_ARADDR_IN,
  input  wire        S_AXI_ARVALID_IN,
  output reg         S_AXI_ARREADY_OUT,
  output reg  [31:0] S_AXI_RDATA_OUT,
  output reg  [1:0]  S_AXI_RRESP_OUT,
  output reg         S_AXI_RVALID_OUT,
  input  wire        S_AXI_RREADY_IN
);

  localparam P_TYPE = 5'h01;
  localparam P_LLO  = 5'h02;
  localparam P_LHI  = 5'h04;
  localparam P_PAY  = 5'h08;
  localparam P_CHK  = 5'h10;

  // ---------------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------------
  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = (addr == `CRF_OFS_CTRL) || (addr == `CRF_OFS_STATUS) || (addr == `CRF_OFS_REPLY_LEN) ||
                  (addr == `CRF_OFS_BUF_ADDR) || (addr == `CRF_OFS_BUF_DATA);
    end
  endfunction

  reg  [4:0]  p_state_reg;
  reg  [7:0]  p_type_reg;
  reg  [7:0]  p_xor_reg;
  reg  [7:0]  p_len_lo_reg;
  reg  [15:0] p_len_reg;
  reg  [15:0] p_left_reg;
  reg  [4:0]  p_idx_reg;
  reg         frame_ok_reg;
  reg         frame_bad_reg;
  reg  [1:0]  code_reg;
  reg  [5:0]  reply_len_reg;
  reg  [4:0]  buf_addr_reg;
  reg         reply_req_reg;
  reg         pend_reg;
  reg         pwroff_reg;
  reg  [7:0]  bad_cnt_reg;
  reg  [7:0]  cmd_len_reg;
  reg         tx_busy_reg;
  reg  [7:0]  tx_type_reg;
  reg  [5:0]  tx_npay_reg;
  reg  [6:0]  tx_idx_reg;
  reg         tx_wait_reg;
  reg  [7:0]  tx_xor_reg;
  reg  [4:0]  tx_chunk_reg;
  reg         tx_end_reg;
  reg         aw_full_reg;
  reg         w_full_reg;
  reg  [7:0]  awaddr_reg;
  reg  [31:0] wdata_reg;
  reg  [3:0]  wstrb_reg;
  reg  [7:0]  tx_byte;
  wire [7:0]  cmd_rd;
  wire [7:0]  reply_rd;

  // ---------------------------------------------------------------------------
  // received frame parser
  // ---------------------------------------------------------------------------
  // the link has no back-pressure, so every byte is taken when it shows up
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      p_state_reg   <= P_TYPE;
      p_type_reg    <= 8'h00;
      p_xor_reg     <= 8'h00;
      p_len_lo_reg  <= 8'h00;
      p_len_reg     <= 16'h0000;
      p_left_reg    <= 16'h0000;
      p_idx_reg     <= 5'h00;
      frame_ok_reg  <= 1'b0;
      frame_bad_reg <= 1'b0;
    end else begin
      frame_ok_reg  <= 1'b0;
      frame_bad_reg <= 1'b0;
      if (RX_VALID_IN) begin
        case (p_state_reg)
          P_TYPE: begin
            p_type_reg  <= RX_DATA_IN;
            p_xor_reg   <= RX_DATA_IN;
            p_state_reg <= P_LLO;
          end
          P_LLO: begin
            p_len_lo_reg <= RX_DATA_IN;
            p_xor_reg    <= p_xor_reg ^ RX_DATA_IN;
            p_state_reg  <= P_LHI;
          end
          P_LHI: begin
            p_len_reg   <= {RX_DATA_IN, p_len_lo_reg};
            p_left_reg  <= {RX_DATA_IN, p_len_lo_reg} - 16'h0001;
            p_xor_reg   <= p_xor_reg ^ RX_DATA_IN;
            p_idx_reg   <= 5'h00;
            if ({RX_DATA_IN, p_len_lo_reg} == 16'h0000) begin
              p_state_reg <= P_TYPE;                              // no room for a check byte: resync
            end else if ({RX_DATA_IN, p_len_lo_reg} == `CRF_LEN_NOPAY) begin
              p_state_reg <= P_CHK;
            end else begin
              p_state_reg <= P_PAY;
            end
          end
          P_PAY: begin
            p_xor_reg  <= p_xor_reg ^ RX_DATA_IN;
            p_left_reg <= p_left_reg - 16'h0001;
            p_idx_reg  <= p_idx_reg + 5'h01;
            if (p_left_reg == 16'h0001) begin
              p_state_reg <= P_CHK;
            end
          end
          P_CHK: begin
            frame_ok_reg  <= (RX_DATA_IN == p_xor_reg);
            frame_bad_reg <= (RX_DATA_IN != p_xor_reg);
            p_state_reg   <= P_TYPE;
          end
          default: begin
            p_state_reg <= P_TYPE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // frame classification
  // ---------------------------------------------------------------------------
  wire is_off   = (p_type_reg == `CRF_T_PWROFF) && (p_len_reg == `CRF_LEN_NOPAY);
  wire is_pres  = (p_type_reg == `CRF_T_PRESENCE) && (p_len_reg == `CRF_LEN_NOPAY);
  wire is_apdu  = (p_type_reg == `CRF_T_APDU) && (p_len_reg > `CRF_LEN_NOPAY) &&
                  (p_len_reg <= `CRF_LEN_MAXPAY);
  wire ctrl_go  = frame_ok_reg && (is_off || is_pres) && !tx_busy_reg;
  wire reply_go = !tx_busy_reg && !ctrl_go && reply_req_reg;
  wire cmd_we   = RX_VALID_IN && (p_state_reg == P_PAY) && (p_type_reg == `CRF_T_APDU) &&
                  !pend_reg && (p_left_reg <= {10'h000, `CRF_BUF_BYTES});
  // bus write strobe: address and data both held and no response outstanding
  wire do_wr    = aw_full_reg && w_full_reg && !S_AXI_BVALID_OUT;
  wire wr_ok    = do_wr && is_mapped(awaddr_reg);

  // ---------------------------------------------------------------------------
  // software-visible control and status
  // ---------------------------------------------------------------------------
  // the pending flag blocks new card commands so software never sees a half-overwritten buffer
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      code_reg      <= `CRF_CODE_RESET;
      reply_len_reg <= 6'h00;
      buf_addr_reg  <= 5'h00;
      reply_req_reg <= 1'b0;
      pend_reg      <= 1'b0;
      pwroff_reg    <= 1'b0;
      bad_cnt_reg   <= 8'h00;
      cmd_len_reg   <= 8'h00;
      CARD_OFF_OUT  <= 1'b0;
    end else begin
      CARD_OFF_OUT <= ctrl_go && is_off;
      if (wr_ok && (awaddr_reg == `CRF_OFS_CTRL)) begin
        if (wstrb_reg[0]) begin
          code_reg <= wdata_reg[1:0];
        end
        if (wstrb_reg[1] && wdata_reg[`CRF_CTRL_GO_BIT] && pend_reg) begin
          reply_req_reg <= 1'b1;
        end
      end
      if (wr_ok && (awaddr_reg == `CRF_OFS_STATUS) && wstrb_reg[0] && wdata_reg[`CRF_ST_PWROFF_BIT]) begin
        pwroff_reg <= 1'b0;
      end
      if (wr_ok && (awaddr_reg == `CRF_OFS_REPLY_LEN) && wstrb_reg[0]) begin
        reply_len_reg <= (wdata_reg[5:0] > `CRF_BUF_BYTES) ? `CRF_BUF_BYTES : wdata_reg[5:0];
      end
      if (wr_ok && (awaddr_reg == `CRF_OFS_BUF_ADDR) && wstrb_reg[0]) begin
        buf_addr_reg <= wdata_reg[4:0];
      end
      if (reply_go) begin
        reply_req_reg <= 1'b0;
        pend_reg      <= 1'b0;
      end
      // hardware sets come last so they win over a clear in the same cycle
      if (ctrl_go && is_off) begin
        pwroff_reg <= 1'b1;
      end
      if (frame_ok_reg && is_apdu && !pend_reg) begin
        pend_reg    <= 1'b1;
        cmd_len_reg <= p_len_reg[7:0] - 8'h01;
      end
      if (frame_bad_reg && (bad_cnt_reg != 8'hFF)) begin
        bad_cnt_reg <= bad_cnt_reg + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // answer frame builder
  // ---------------------------------------------------------------------------
  wire [6:0] tx_last_idx = {1'b0, tx_npay_reg} + `CRF_HDR_BYTES;
  wire [7:0] tx_len_lo   = {2'h0, tx_npay_reg} + 8'h01;
  wire [6:0] tx_mem_idx  = tx_idx_reg - `CRF_HDR_BYTES;
  wire       tx_load     = tx_busy_reg && !tx_wait_reg && (tx_idx_reg <= tx_last_idx) &&
                           (!TX_VALID_OUT || TX_READY_IN);

  // byte at the current index of the frame being built
  always @* begin
    if (tx_idx_reg == 7'h00) begin
      tx_byte = tx_type_reg;
    end else if (tx_idx_reg == 7'h01) begin
      tx_byte = tx_len_lo;
    end else if (tx_idx_reg == 7'h02) begin
      tx_byte = 8'h00;
    end else if (tx_idx_reg == tx_last_idx) begin
      tx_byte = tx_xor_reg;
    end else if (tx_type_reg == `CRF_R_PRESENCE) begin
      tx_byte = {6'h00, code_reg};
    end else begin
      tx_byte = reply_rd;
    end
  end

  // one idle cycle after each byte lets the reply buffer read settle
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      tx_busy_reg  <= 1'b0;
      tx_type_reg  <= 8'h00;
      tx_npay_reg  <= 6'h00;
      tx_idx_reg   <= 7'h00;
      tx_wait_reg  <= 1'b0;
      tx_xor_reg   <= 8'h00;
      tx_chunk_reg <= 5'h00;
      tx_end_reg   <= 1'b0;
      TX_DATA_OUT  <= 8'h00;
      TX_VALID_OUT <= 1'b0;
      TX_LAST_OUT  <= 1'b0;
    end else begin
      tx_wait_reg <= 1'b0;
      if (ctrl_go) begin
        tx_busy_reg <= 1'b1;
        tx_type_reg <= is_off ? `CRF_R_PWROFF : `CRF_R_PRESENCE;
        tx_npay_reg <= is_off ? 6'h00 : 6'h01;
        tx_idx_reg  <= 7'h00;
        tx_xor_reg  <= 8'h00;
        tx_wait_reg <= 1'b1;
      end else if (reply_go) begin
        tx_busy_reg <= 1'b1;
        tx_type_reg <= `CRF_R_APDU;
        tx_npay_reg <= reply_len_reg;
        tx_idx_reg  <= 7'h00;
        tx_xor_reg  <= 8'h00;
        tx_wait_reg <= 1'b1;
      end else if (tx_load) begin
        TX_DATA_OUT  <= tx_byte;
        TX_VALID_OUT <= 1'b1;
        TX_LAST_OUT  <= (tx_idx_reg == tx_last_idx) || (tx_chunk_reg == `CRF_CHUNK_LAST);
        tx_end_reg   <= (tx_idx_reg == tx_last_idx);
        tx_chunk_reg <= ((tx_idx_reg == tx_last_idx) || (tx_chunk_reg == `CRF_CHUNK_LAST)) ? 5'h00 :
                        tx_chunk_reg + 5'h01;
        tx_xor_reg   <= tx_xor_reg ^ tx_byte;
        tx_idx_reg   <= tx_idx_reg + 7'h01;
        tx_wait_reg  <= 1'b1;
      end else if (TX_VALID_OUT && TX_READY_IN) begin
        TX_VALID_OUT <= 1'b0;
        TX_LAST_OUT  <= 1'b0;
        if (tx_end_reg) begin
          tx_busy_reg <= 1'b0;
          tx_end_reg  <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // payload buffers
  // ---------------------------------------------------------------------------
  crf_mem u_cmd_mem (
    .clk_in      (SYS_CLK_IN),
    .resetn_in   (RESETN_IN),
    .wr_en_in    (cmd_we),
    .wr_addr_in  (p_idx_reg),
    .wr_data_in  (RX_DATA_IN),
    .rd_addr_in  (buf_addr_reg),
    .rd_data_out (cmd_rd)
  );

  crf_mem u_reply_mem (
    .clk_in      (SYS_CLK_IN),
    .resetn_in   (RESETN_IN),
    .wr_en_in    (wr_ok && (awaddr_reg == `CRF_OFS_BUF_DATA) && wstrb_reg[0]),
    .wr_addr_in  (buf_addr_reg),
    .wr_data_in  (wdata_reg[7:0]),
    .rd_addr_in  (tx_mem_idx[4:0]),
    .rd_data_out (reply_rd)
  );

  // ---------------------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------------------
  // address and data are held separately, so either may arrive first
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      aw_full_reg       <= 1'b0;
      w_full_reg        <= 1'b0;
      awaddr_reg        <= 8'h00;
      wdata_reg         <= 32'h00000000;
      wstrb_reg         <= 4'h0;
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT  <= 1'b1;
      S_AXI_BVALID_OUT  <= 1'b0;
      S_AXI_BRESP_OUT   <= `CRF_RESP_OKAY;
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h00000000;
      S_AXI_RRESP_OUT   <= `CRF_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) begin
        aw_full_reg       <= 1'b1;
        awaddr_reg        <= S_AXI_AWADDR_IN;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT) begin
        w_full_reg       <= 1'b1;
        wdata_reg        <= S_AXI_WDATA_IN;
        wstrb_reg        <= S_AXI_WSTRB_IN;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (do_wr) begin
        aw_full_reg      <= 1'b0;
        w_full_reg       <= 1'b0;
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT  <= is_mapped(awaddr_reg) ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
      end
      if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT  <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT  <= 1'b1;
      end
      if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT) begin
        S_AXI_ARREADY_OUT <= 1'b0;
        S_AXI_RVALID_OUT  <= 1'b1;
        S_AXI_RRESP_OUT   <= is_mapped(S_AXI_ARADDR_IN) ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
        case (S_AXI_ARADDR_IN)
          `CRF_OFS_CTRL:      S_AXI_RDATA_OUT <= {23'h000000, reply_req_reg, 6'h00, code_reg};
          `CRF_OFS_STATUS:    S_AXI_RDATA_OUT <= {8'h00, bad_cnt_reg, cmd_len_reg, 5'h00, tx_busy_reg,
                                                  pwroff_reg, pend_reg};
          `CRF_OFS_REPLY_LEN: S_AXI_RDATA_OUT <= {26'h0000000, reply_len_reg};
          `CRF_OFS_BUF_ADDR:  S_AXI_RDATA_OUT <= {27'h0000000, buf_addr_reg};
          `CRF_OFS_BUF_DATA:  S_AXI_RDATA_OUT <= {24'h000000, cmd_rd};
          default:            S_AXI_RDATA_OUT <= 32'h00000000;
        endcase
      end else if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT  <= 1'b0;
        S_AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// File: inc/crf_regs.vh
// constants for the card reader command frame engine
// assumes one 10 MHz clock and an AXI4-Lite master with byte addressing
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// ----------------------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------------------
`define CRF_OFS_CTRL      8'h00
`define CRF_OFS_STATUS    8'h04
`define CRF_OFS_REPLY_LEN 8'h08
`define CRF_OFS_BUF_ADDR  8'h0C
`define CRF_OFS_BUF_DATA  8'h10

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define CRF_CTRL_GO_BIT     8
`define CRF_ST_PEND_BIT     0
`define CRF_ST_PWROFF_BIT   1
`define CRF_CODE_RESET      2'h0
`define CRF_RESP_OKAY       2'h0
`define CRF_RESP_SLVERR     2'h2

// ----------------------------------------------------------------------------
// frame codes and sizes
// ----------------------------------------------------------------------------
`define CRF_T_PWROFF   8'h63
`define CRF_T_PRESENCE 8'h65
`define CRF_T_APDU     8'h6F
`define CRF_R_PWROFF   8'h13
`define CRF_R_PRESENCE 8'h14
`define CRF_R_APDU     8'h11
`define CRF_LEN_NOPAY  16'h0001
`define CRF_LEN_MAXPAY 16'h0021
`define CRF_BUF_BYTES  6'h20
`define CRF_CHUNK_LAST 5'h13
`define CRF_HDR_BYTES  7'h03

`endif

// File: verilog/crf_mem.v
// byte buffer for card command and card reply payloads
// assumes one clock; read data is registered, one cycle after the address
`timescale 1ns/10ps
`default_nettype none

module crf_mem (
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       wr_en_in,
  input  wire [4:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  input  wire [4:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);

  reg [7:0] mem_array [0:31];

  // ---------------------------------------------------------------------------
  // storage and registered read
  // ---------------------------------------------------------------------------
  // array itself has no reset, only the read register does
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_array[wr_addr_in] <= wr_data_in;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem_array[rd_addr_in];
    end
  end

endmodule

`default_nettype wire

// File: bench/crf_top_properties.sv
// checker for the answer stream and the card power-off pulse
// assumes it is bound to crf_top and sees only that module's ports
`timescale 1ns/10ps
`default_nettype none
module crf_props (
  input wire logic       SYS_CLK_IN,
  input wire logic       RESETN_IN,
  input wire logic [7:0] RX_DATA_IN,
  input wire logic       RX_VALID_IN,
  input wire logic [7:0] TX_DATA_OUT,
  input wire logic       TX_VALID_OUT,
  input wire logic       TX_LAST_OUT,
  input wire logic       TX_READY_IN,
  input wire logic       CARD_OFF_OUT
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // ----------------------------------------------------------------
  // frame tracker on the answer stream
  // ----------------------------------------------------------------
  logic       hs;
  logic       end_w;
  logic       off_chk;
  logic [7:0] idx_reg;
  logic [7:0] typ_reg;
  logic [7:0] len_reg;
  logic [7:0] acc_reg;
  assign hs = TX_VALID_OUT && TX_READY_IN;
  assign end_w = (idx_reg >= 8'h03) && (idx_reg == len_reg + 8'h02);  // length known from byte 2 on
  assign off_chk = RX_VALID_IN && (RX_DATA_IN == 8'h62);
  // byte index, type, length and running xor of the frame being sent
  always @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      idx_reg <= 8'h00;
      typ_reg <= 8'h00;
      len_reg <= 8'h00;
      acc_reg <= 8'h00;
    end else if (hs) begin
      idx_reg <= end_w ? 8'h00 : idx_reg + 8'h01;
      acc_reg <= (idx_reg == 8'h00) ? TX_DATA_OUT : acc_reg ^ TX_DATA_OUT;
      if (idx_reg == 8'h00) typ_reg <= TX_DATA_OUT;
      if (idx_reg == 8'h01) len_reg <= TX_DATA_OUT;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence off_frame_s;
    RX_VALID_IN && RX_DATA_IN == 8'h63 ##1 RX_VALID_IN && RX_DATA_IN == 8'h01 ##1
    RX_VALID_IN && RX_DATA_IN == 8'h00 ##1 off_chk;
  endsequence
  sequence off_answer_s;
    ##[1:4] TX_VALID_OUT && TX_DATA_OUT == 8'h13;
  endsequence
  tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN |=>
    TX_VALID_OUT && $stable(TX_DATA_OUT) && $stable(TX_LAST_OUT)) else $error("answer byte changed early");
  tx_check_a: assert property (hs && end_w |-> TX_DATA_OUT == acc_reg)
    else $error("answer check byte wrong");
  tx_last_a: assert property (hs |-> TX_LAST_OUT == (end_w || idx_reg == 8'h13 || idx_reg == 8'h27))
    else $error("packet end flag wrong");
  len_high_a: assert property (hs && idx_reg == 8'h02 |-> TX_DATA_OUT == 8'h00)
    else $error("length high byte wrong");
  pres_len_a: assert property (hs && idx_reg == 8'h01 && typ_reg == 8'h14 |-> TX_DATA_OUT == 8'h02)
    else $error("presence length wrong");
  pres_code_a: assert property (hs && idx_reg == 8'h03 && typ_reg == 8'h14 |-> TX_DATA_OUT <= 8'h03)
    else $error("presence code out of range");
  off_once_a: assert property (CARD_OFF_OUT |=> !CARD_OFF_OUT)
    else $error("power-off pulse too long");
  off_answer_a: assert property ($rose(CARD_OFF_OUT) |-> off_answer_s)
    else $error("power-off answer missing");
  off_cause_a: assert property (CARD_OFF_OUT |->
    $past(off_chk, 1) || $past(off_chk, 2) || $past(off_chk, 3)) else $error("power-off without request");
  off_seen_c: cover property (off_frame_s);
endmodule
bind crf_top crf_props i_props (
  .SYS_CLK_IN   (SYS_CLK_IN),
  .RESETN_IN    (RESETN_IN),
  .RX_DATA_IN   (RX_DATA_IN),
  .RX_VALID_IN  (RX_VALID_IN),
  .TX_DATA_OUT  (TX_DATA_OUT),
  .TX_VALID_OUT (TX_VALID_OUT),
  .TX_LAST_OUT  (TX_LAST_OUT),
  .TX_READY_IN  (TX_READY_IN),
  .CARD_OFF_OUT (CARD_OFF_OUT)
);
`default_nettype wire

// File: bench/crf_host_model.sv
// paired host model: sends command frames, drains answer bytes
// assumes the reader samples link bytes on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module crf_host_model (
  input  wire logic       clk_in,
  output var  logic [7:0] rx_data_out,
  output var  logic       rx_valid_out,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  input  wire logic       tx_last_in,
  output var  logic       tx_ready_out
);
  logic [7:0] got_q[$];
  logic       last_q[$];
  int         stall = 0;  // wait cycles before each ready
  int         cnt = 0;
  initial begin
    rx_data_out = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // whole frame, back to back; bad flips the check byte
  task automatic send_frame(input logic [7:0] typ, input logic [7:0] pay[$], input logic bad);
    logic [7:0] b[$];
    logic [7:0] x;
    b = {typ, 8'(pay.size() + 1), 8'h00};
    b = {b, pay};
    x = 8'h00;
    foreach (b[i]) x ^= b[i];
    b.push_back(bad ? ~x : x);
    foreach (b[i]) begin
      @(posedge clk_in);
      rx_data_out <= b[i];
      rx_valid_out <= 1'b1;
    end
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    rx_data_out <= ~b[b.size() - 1];  // released line must not show a stale byte
  endtask
  // ready only after the stall count, so slow sinks are exercised
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got_q.push_back(tx_data_in);
      last_q.push_back(tx_last_in);
      tx_ready_out <= 1'b0;
      cnt <= 0;
    end else if (tx_valid_in && cnt >= stall) begin
      tx_ready_out <= 1'b1;
    end else if (tx_valid_in) begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: bench/card_reader_command_frames_test.sv
// self-checking bench for crf_top with a host model on the link
// assumes crf_regs.vh on the include path and the bound checker
`timescale 1ns/10ps
`default_nettype none
`include "crf_regs.vh"
module card_reader_command_frames_test;
  typedef logic [7:0] crf_bytes_t[$];
  logic        clk, rstn, rx_valid, tx_valid, tx_last, tx_ready, card_off;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0]  rx_data, tx_data, awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  crf_bytes_t  nopay;
  int          num_errors = 0;
  int          checks = 0;
  int          offs = 0;
  crf_top i_dut (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .RX_DATA_IN(rx_data), .RX_VALID_IN(rx_valid),
    .TX_DATA_OUT(tx_data), .TX_VALID_OUT(tx_valid), .TX_LAST_OUT(tx_last), .TX_READY_IN(tx_ready),
    .CARD_OFF_OUT(card_off), .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(4'hF),
    .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp),
    .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata),
    .S_AXI_RRESP_OUT(rresp), .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
  crf_host_model i_host (.clk_in(clk), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_last_in(tx_last), .tx_ready_out(tx_ready));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // count power-off pulses seen at the port
  always @(posedge clk) if (card_off === 1'b1) offs++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one write; address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw, w, b;
    aw = 1;
    w = 1;
    b = 1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (b) begin
      @(posedge clk);
      if (aw && awready) begin
        aw = 0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        b = 0;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar;
    ar = 1;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (ar && arready) begin
        ar = 0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  // expected answer frame with its xor check appended
  function automatic crf_bytes_t mk(input logic [7:0] typ, input crf_bytes_t pay);
    logic [7:0] x;
    mk = {typ, 8'(pay.size() + 1), 8'h00, pay};
    x = 8'h00;
    foreach (mk[i]) x ^= mk[i];
    mk.push_back(x);
  endfunction
  // waits for the bytes, then a quiet spell so extra bytes show up too
  task automatic expect_frame(input crf_bytes_t e);
    int n;
    n = 0;
    while (i_host.got_q.size() < e.size() && n < 400) begin
      @(posedge clk);
      n++;
    end
    repeat (20) @(posedge clk);
    check(i_host.got_q.size(), e.size());
    foreach (e[i]) begin
      check(i_host.got_q[i], e[i]);
      check(i_host.last_q[i], (i == e.size() - 1) || (i % 20 == 19));
    end
    i_host.got_q.delete();
    i_host.last_q.delete();
  endtask
  task automatic t_power_off();
    i_host.send_frame(`CRF_T_PWROFF, nopay, 1'b0);
    expect_frame('{8'h13, 8'h01, 8'h00, 8'h12});
    check(offs, 1);
  endtask
  // every presence code, with a sink slower each round
  task automatic t_presence();
    logic [1:0] r;
    for (int c = 0; c < 4; c++) begin
      i_host.stall = c;
      axi_wr(`CRF_OFS_CTRL, c, r);
      i_host.send_frame(`CRF_T_PRESENCE, nopay, 1'b0);
      expect_frame('{8'h14, 8'h02, 8'h00, 8'(c), 8'h16 ^ 8'(c)});
    end
  endtask
  task automatic t_bad_check();
    logic [31:0] d;
    logic [1:0]  r;
    i_host.send_frame(`CRF_T_PRESENCE, nopay, 1'b1);
    i_host.send_frame(`CRF_T_PWROFF, nopay, 1'b1);
    expect_frame(nopay);
    check(offs, 1);
    axi_rd(`CRF_OFS_STATUS, d, r);
    check(d[23:16], 8'h02);
    check(d[1], 1'b1);
    axi_wr(`CRF_OFS_STATUS, 32'h2, r);
    axi_rd(`CRF_OFS_STATUS, d, r);
    check(d[1:0], 2'h0);
  endtask
  // command in, buffer read back, 20-byte reply split into link packets
  task automatic t_apdu();
    crf_bytes_t  cmd, rep;
    logic [31:0] d;
    logic [1:0]  r;
    cmd = '{8'h80, 8'h84, 8'h00, 8'h00, 8'h08};
    i_host.send_frame(`CRF_T_APDU, cmd, 1'b0);
    repeat (3) @(posedge clk);
    axi_rd(`CRF_OFS_STATUS, d, r);
    check({d[15:8], d[0]}, {8'h05, 1'b1});
    foreach (cmd[i]) begin
      axi_wr(`CRF_OFS_BUF_ADDR, i, r);
      axi_rd(`CRF_OFS_BUF_DATA, d, r);
      check(d, cmd[i]);
    end
    for (int i = 0; i < 20; i++) begin
      rep.push_back(8'(i * 7 + 1));
      axi_wr(`CRF_OFS_BUF_ADDR, i, r);
      axi_wr(`CRF_OFS_BUF_DATA, rep[i], r);
    end
    axi_wr(`CRF_OFS_REPLY_LEN, 32'h14, r);
    check(r, `CRF_RESP_OKAY);
    i_host.stall = 1;
    axi_wr(`CRF_OFS_CTRL, 32'h103, r);
    expect_frame(mk(`CRF_R_APDU, rep));
    axi_wr(8'h40, 32'h1, r);
    check(r, `CRF_RESP_SLVERR);
    axi_rd(8'h40, d, r);
    check(r, `CRF_RESP_SLVERR);
  endtask
  initial begin
    rstn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_power_off();
    t_presence();
    t_bad_check();
    t_apdu();
    stop_test();
  end
  // the run needs well under 10k cycles; 50k means a hang
  initial begin
    #5_000_000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
